// File: pkg/flash_host_consts.svh
// timing counts, command words and address map for the parallel flash host
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

`define CLK_PERIOD_NS     8
`define T_AS_NS           10
`define T_WP_NS           100
`define T_AH_NS           50
`define T_WPH_NS          100
`define T_ACC_NS          120
`define MIN_STROBE_HIGH_PULSE_NS 150
`define T_BP_US           50
`define T_EC_S            10
`define SYNC_STAGES       2

// least times round up, longest times round down
`define CYC_MIN(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AS_CYC            `CYC_MIN(`T_AS_NS)
`define WP_CYC            `CYC_MIN(`T_WP_NS)
`define AH_CYC            `CYC_MIN(`T_AH_NS)
`define WPH_CYC           `CYC_MIN(`T_WPH_NS)
`define RD_CYC            (`CYC_MIN(`T_ACC_NS) + `SYNC_STAGES + 1)
`define MIN_STROBE_HIGH_PULSE_CYC `CYC_MIN(`MIN_STROBE_HIGH_PULSE_NS)
`define BP_CYC            ((`T_BP_US * 1000) / `CLK_PERIOD_NS)
`define EC_CYC            (`T_EC_S * (1000000000 / `CLK_PERIOD_NS))

`define CHIP_ERASE_ADDR   17'h05555
`define CHIP_ERASE_CODE   8'h10
`define SECTOR_ERASE_CODE 8'h30
`define CMD_HIGH_BYTE     8'h00
`define TOGGLE_BIT        6
`define BOOT_FIRST_ADDR   17'h00000
`define BOOT_LAST_ADDR    17'h01FFF

`endif

// File: pkg/flash_host_pkg.sv
// types shared by the flash host modules
`default_nettype none
package flash_host_pkg;
	typedef enum logic [2:0] {
		OP_READ         = 3'h0,
		OP_WRITE        = 3'h1,
		OP_PROGRAM      = 3'h2,
		OP_CHIP_ERASE   = 3'h3,
		OP_SECTOR_ERASE = 3'h4
	} op_t;

	typedef enum logic [2:0] {
		B_IDLE    = 3'h0,
		B_SETUP   = 3'h1,
		B_STROBE  = 3'h2,
		B_HOLD    = 3'h3,
		B_RECOVER = 3'h4
	} bus_state_t;

	typedef enum logic [2:0] {
		M_IDLE      = 3'h0,
		M_GO        = 3'h1,
		M_WAIT      = 3'h2,
		M_POLL_GO   = 3'h3,
		M_POLL_WAIT = 3'h4
	} main_state_t;
endpackage
`default_nettype wire

// File: logic/flash_bus_cycle.sv
// one timed read or write strobe cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.svh"
module flash_bus_cycle import flash_host_pkg::*; (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_start,
	input  wire logic        i_write,
	input  wire logic [16:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [15:0] i_dq_in,
	output logic             o_idle,
	output logic             o_done,
	output logic [15:0]      o_rdata,
	output logic             o_ce_n,
	output logic             o_oe_n,
	output logic             o_we_n,
	output logic [16:0]      o_addr,
	output logic [15:0]      o_dq_out,
	output logic             o_dq_oe
);
	bus_state_t  state, next_state;
	logic [7:0]  cnt, next_cnt;
	logic        wr, next_wr;
	logic [16:0] next_addr;
	logic [15:0] next_dq_out, next_rdata;
	logic        next_dq_oe, next_ce_n, next_oe_n, next_we_n, next_done;
	logic [15:0] dq_meta, dq_sync;

	// pin data is asynchronous to us: two stages before anything looks at it
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			dq_meta <= 16'h0000;
			dq_sync <= 16'h0000;
		end else begin
			dq_meta <= i_dq_in;
			dq_sync <= dq_meta;
		end
	end

	// strobe sequencer; oe stays high for the whole write
	always_comb begin
		next_state  = state;
		next_cnt    = cnt;
		next_wr     = wr;
		next_addr   = o_addr;
		next_dq_out = o_dq_out;
		next_dq_oe  = o_dq_oe;
		next_ce_n   = o_ce_n;
		next_oe_n   = o_oe_n;
		next_we_n   = o_we_n;
		next_rdata  = o_rdata;
		next_done   = 1'b0;
		case (state)
			B_IDLE: begin
				if (i_start) begin
					next_wr     = i_write;
					next_addr   = i_addr;
					next_dq_out = i_wdata;
					next_dq_oe  = i_write;
					next_ce_n   = 1'b0;
					next_cnt    = 8'(`AS_CYC - 1);
					next_state  = B_SETUP;
				end
			end
			B_SETUP: begin
				if (cnt == 8'h00) begin
					if (wr) begin
						next_we_n = 1'b0; // (RULE3)
						next_cnt  = 8'(`WP_CYC - 1);
					end else begin
						next_oe_n = 1'b0;
						next_cnt  = 8'(`RD_CYC - 1);
					end
					next_state = B_STROBE;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			B_STROBE: begin
				if (cnt != 8'h00) begin
					next_cnt = cnt - 8'h01;
				end else if (wr) begin
					next_we_n  = 1'b1;
					next_cnt   = 8'(`AH_CYC - 1);
					next_state = B_HOLD;
				end else begin
					// oe and ce rise together; high time counted in recover
					next_rdata = dq_sync;
					next_oe_n  = 1'b1;
					next_ce_n  = 1'b1;
					next_done  = 1'b1;
					next_cnt   = 8'(`MIN_STROBE_HIGH_PULSE_CYC - 1); // (RULE7)
					next_state = B_RECOVER;
				end
			end
			B_HOLD: begin
				if (cnt == 8'h00) begin
					next_ce_n  = 1'b1;
					next_dq_oe = 1'b0;
					next_done  = 1'b1;
					next_cnt   = 8'(`WPH_CYC - `AH_CYC - 1);
					next_state = B_RECOVER;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			B_RECOVER: begin
				if (cnt == 8'h00) begin
					next_state = B_IDLE;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			default: begin
				next_state = B_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			state    <= B_IDLE;
			cnt      <= 8'h00;
			wr       <= 1'b0;
			o_addr   <= 17'h00000;
			o_dq_out <= 16'h0000;
			o_dq_oe  <= 1'b0;
			o_ce_n   <= 1'b1;
			o_oe_n   <= 1'b1;
			o_we_n   <= 1'b1;
			o_rdata  <= 16'h0000;
			o_done   <= 1'b0;
		end else begin
			state    <= next_state;
			cnt      <= next_cnt;
			wr       <= next_wr;
			o_addr   <= next_addr;
			o_dq_out <= next_dq_out;
			o_dq_oe  <= next_dq_oe;
			o_ce_n   <= next_ce_n;
			o_oe_n   <= next_oe_n;
			o_we_n   <= next_we_n;
			o_rdata  <= next_rdata;
			o_done   <= next_done;
		end
	end

	assign o_idle = (state == B_IDLE);

	// helper: cycles since oe last rose, saturating
	logic [7:0] oe_high_cnt;
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			oe_high_cnt <= 8'hFF;
		end else if (!o_oe_n) begin
			oe_high_cnt <= 8'h00;
		end else if (oe_high_cnt != 8'hFF) begin
			oe_high_cnt <= oe_high_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	oe_write_guard_a: assert property ((!o_we_n && !o_ce_n) |-> o_oe_n) // (RULE3)
		else $error("oe low while a write strobe is active");
	// counter equals whole high cycles at the falling edge, so no minus one here
	oe_high_time_a: assert property ($fell(o_oe_n) |-> oe_high_cnt >= 8'(`MIN_STROBE_HIGH_PULSE_CYC)) // (RULE7)
		else $error("oe high pulse between reads too short");
	cycle_length_a: assert property ((o_idle && i_start) |-> ##[20:23] o_done)
		else $error("bus cycle did not finish in its window");
endmodule
`default_nettype wire

// File: logic/flash_host.sv
// host controller for a 16-bit parallel flash: raw cycles, erase and toggle polling
// Rules of the flash device that this block works to
// (RULE1) chip erase ends with a write of 10 hex at address 5555.
// (RULE2) sector erase ends with a write of 30 hex at the sector address.
// (RULE3) output enable stays high while write and chip enable are both low.
// (RULE4) device flips bit 6 on each read while busy; host watches for it to stop.
// (RULE5) status polling reads reuse one fixed address.
// (RULE6) only a change between successive bit 6 reads matters, never its value.
// (RULE7) output enable stays high at least 150 ns between polling reads.
// (RULE8) commands use the low data byte and address bits 14 to 0.
// (RULE9) in id mode, address bit 0 picks maker or device code.
// (RULE10) device leaves id mode on power loss, starting in normal reads.
// (RULE11) id exit command returns the device to normal reads.
// (RULE12) either id exit command form is accepted by the device.
// (RULE13) one word programs within 50 microseconds.
// (RULE14) boot block sits at word addresses 00000 to 01FFF.
// (RULE15) lockout sequence protects the boot block from further programming.
// (RULE16) unlock and command preambles come from the user as raw writes.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.svh"
module flash_host import flash_host_pkg::*; #(
	parameter int unsigned PROG_TIMEOUT_CYC  = `BP_CYC,
	parameter int unsigned ERASE_TIMEOUT_CYC = `EC_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_cmd_valid,
	input  wire op_t         i_cmd_op,
	input  wire logic [16:0] i_cmd_addr,
	input  wire logic [15:0] i_cmd_data,
	input  wire logic [15:0] i_flash_dq_in,
	output logic             o_cmd_ready,
	output logic             o_cmd_done,
	output logic [15:0]      o_cmd_rdata,
	output logic             o_cmd_timeout,
	output logic             o_flash_ce_n,
	output logic             o_flash_oe_n,
	output logic             o_flash_we_n,
	output logic             o_flash_rst_n,
	output logic [16:0]      o_flash_addr,
	output logic [15:0]      o_flash_dq_out,
	output logic             o_flash_dq_oe
);
	main_state_t state, next_state;
	op_t         op, next_op;
	logic [16:0] addr, next_addr;
	logic [15:0] wdata, next_wdata;
	logic        next_ready, next_cmd_done, next_timeout;
	logic [15:0] next_rdata;
	logic        last_bit, next_last_bit;
	logic        have_last, next_have_last;
	logic [30:0] tcnt, next_tcnt;

	logic        bus_start, bus_write, bus_idle, bus_done;
	logic [15:0] bus_rdata;
	logic        toggle_now;

	assign toggle_now = bus_rdata[`TOGGLE_BIT];

	flash_bus_cycle u_bus (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_start    (bus_start),
		.i_write    (bus_write),
		.i_addr     (addr),
		.i_wdata    (wdata),
		.i_dq_in    (i_flash_dq_in),
		.o_idle     (bus_idle),
		.o_done     (bus_done),
		.o_rdata    (bus_rdata),
		.o_ce_n     (o_flash_ce_n),
		.o_oe_n     (o_flash_oe_n),
		.o_we_n     (o_flash_we_n),
		.o_addr     (o_flash_addr),
		.o_dq_out   (o_flash_dq_out),
		.o_dq_oe    (o_flash_dq_oe)
	);

	// command sequencer; erase and program finish with toggle polling
	always_comb begin
		next_state     = state;
		next_op        = op;
		next_addr      = addr;
		next_wdata     = wdata;
		next_ready     = o_cmd_ready;
		next_cmd_done  = 1'b0;
		next_timeout   = o_cmd_timeout;
		next_rdata     = o_cmd_rdata;
		next_last_bit  = last_bit;
		next_have_last = have_last;
		next_tcnt      = tcnt;
		bus_start      = 1'b0;
		bus_write      = 1'b0;
		case (state)
			M_IDLE: begin
				next_ready = 1'b1;
				if (i_cmd_valid && o_cmd_ready) begin
					next_op      = i_cmd_op;
					next_addr    = i_cmd_addr;
					next_wdata   = i_cmd_data;
					next_ready   = 1'b0;
					next_timeout = 1'b0;
					next_state   = M_GO;
					if (i_cmd_op == OP_CHIP_ERASE) begin
						next_addr  = `CHIP_ERASE_ADDR; // (RULE1)
						next_wdata = {`CMD_HIGH_BYTE, `CHIP_ERASE_CODE}; // (RULE8)
					end else if (i_cmd_op == OP_SECTOR_ERASE) begin
						next_wdata = {`CMD_HIGH_BYTE, `SECTOR_ERASE_CODE}; // (RULE2)
					end
				end
			end
			M_GO: begin
				if (bus_idle) begin
					bus_start  = 1'b1;
					bus_write  = (op != OP_READ);
					next_state = M_WAIT;
				end
			end
			M_WAIT: begin
				if (bus_done) begin
					if (op == OP_READ || op == OP_WRITE) begin
						// raw cycles carry unlock preambles chosen by the user
						next_rdata    = bus_rdata; // (RULE16)
						next_cmd_done = 1'b1;
						next_ready    = 1'b1;
						next_state    = M_IDLE;
					end else begin
						next_have_last = 1'b0;
						next_tcnt      = (op == OP_PROGRAM) ? 31'(PROG_TIMEOUT_CYC)
						                                    : 31'(ERASE_TIMEOUT_CYC);
						next_state     = M_POLL_GO;
					end
				end
			end
			M_POLL_GO: begin
				// addr is left untouched so every poll reads one location
				if (bus_idle) begin
					bus_start  = 1'b1; // (RULE5)
					next_state = M_POLL_WAIT;
				end
			end
			M_POLL_WAIT: begin
				if (bus_done) begin
					next_rdata = bus_rdata;
					// first read only seeds the compare; its value means nothing
					if (have_last && toggle_now == last_bit) begin // (RULE4) (RULE6)
						next_cmd_done = 1'b1;
						next_ready    = 1'b1;
						next_state    = M_IDLE;
					end else if (tcnt == 31'h0000_0000) begin
						// device blew its internal time limit; give up
						next_timeout  = 1'b1; // (RULE13)
						next_cmd_done = 1'b1;
						next_ready    = 1'b1;
						next_state    = M_IDLE;
					end else begin
						next_last_bit  = toggle_now;
						next_have_last = 1'b1;
						next_state     = M_POLL_GO;
					end
				end
			end
			default: begin
				next_state = M_IDLE;
			end
		endcase
		// time limit runs across the whole polling phase
		if ((state == M_POLL_GO || state == M_POLL_WAIT) && tcnt != 31'h0000_0000) begin
			next_tcnt = tcnt - 31'h0000_0001;
		end
	end

	// flash reset pin held low while we are in reset, so id mode cannot linger
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			state         <= M_IDLE;
			op            <= OP_READ;
			addr          <= 17'h00000;
			wdata         <= 16'h0000;
			o_cmd_ready   <= 1'b0;
			o_cmd_done    <= 1'b0;
			o_cmd_timeout <= 1'b0;
			o_cmd_rdata   <= 16'h0000;
			last_bit      <= 1'b0;
			have_last     <= 1'b0;
			tcnt          <= 31'h0000_0000;
			o_flash_rst_n <= 1'b0;
		end else begin
			state         <= next_state;
			op            <= next_op;
			addr          <= next_addr;
			wdata         <= next_wdata;
			o_cmd_ready   <= next_ready;
			o_cmd_done    <= next_cmd_done;
			o_cmd_timeout <= next_timeout;
			o_cmd_rdata   <= next_rdata;
			last_bit      <= next_last_bit;
			have_last     <= next_have_last;
			tcnt          <= next_tcnt;
			o_flash_rst_n <= 1'b1;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	chip_erase_word_a: assert property ( // (RULE1)
		(state == M_GO && bus_idle && op == OP_CHIP_ERASE) |-> ##3
		(!o_flash_we_n && o_flash_addr == `CHIP_ERASE_ADDR
		 && o_flash_dq_out[7:0] == `CHIP_ERASE_CODE))
		else $error("chip erase final write wrong");
	sector_erase_word_a: assert property ( // (RULE2)
		(state == M_GO && bus_idle && op == OP_SECTOR_ERASE) |-> ##3
		(!o_flash_we_n && o_flash_addr == $past(addr, 3)
		 && o_flash_dq_out[7:0] == `SECTOR_ERASE_CODE))
		else $error("sector erase final write wrong");
	command_high_byte_a: assert property ( // (RULE8)
		(!o_flash_we_n && (op == OP_CHIP_ERASE || op == OP_SECTOR_ERASE))
		|-> o_flash_dq_out[15:8] == `CMD_HIGH_BYTE)
		else $error("erase command high byte not zero");
	poll_addr_fixed_a: assert property ( // (RULE5)
		(!o_flash_ce_n && (state == M_POLL_GO || state == M_POLL_WAIT))
		|-> (o_flash_addr == addr && $stable(addr)))
		else $error("polling address moved");
	toggle_stop_a: assert property ( // (RULE4)
		(state == M_POLL_WAIT && bus_done && have_last && toggle_now == last_bit)
		|=> (o_cmd_done && o_cmd_ready && !o_cmd_timeout))
		else $error("stable status bit not reported as done");
	first_poll_a: assert property ( // (RULE6)
		(state == M_POLL_WAIT && bus_done && !have_last)
		|=> (!o_cmd_done && state == M_POLL_GO))
		else $error("completion decided on a single read");
	timeout_flag_a: assert property ( // (RULE13)
		(state == M_POLL_WAIT && bus_done && tcnt == 31'h0000_0000
		 && !(have_last && toggle_now == last_bit))
		|=> (o_cmd_done && o_cmd_timeout))
		else $error("time limit not flagged");

	chip_erase_cover: cover property (
		(op == OP_CHIP_ERASE && o_cmd_done && !o_cmd_timeout));
	program_timeout_cover: cover property ((op == OP_PROGRAM && o_cmd_done && o_cmd_timeout));
	raw_read_cover: cover property ((op == OP_READ && o_cmd_done));
endmodule
`default_nettype wire

// File: verification/flash_device_model.sv
// behavioural flash device answering the host's strobes
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
	parameter logic [7:0]  PROG_CODE = 8'hA0,
	parameter logic [7:0]  ID_IN     = 8'h90,
	parameter logic [7:0]  ID_OUT_A  = 8'hF0,
	parameter logic [7:0]  ID_OUT_B  = 8'hFF,
	parameter logic [7:0]  LOCK_CODE = 8'h40,
	parameter logic [15:0] MAKER_ID  = 16'h0011, // arbitrary value
	parameter logic [15:0] PART_ID   = 16'h0022, // arbitrary value
	parameter int          FAST_NS   = 1000,
	parameter int          SLOW_NS   = 40000,
	parameter int          ACC_NS    = 100
) (
	input  wire logic        i_rst_n,
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_slow,
	input  wire logic [16:0] i_addr,
	input  wire logic [15:0] i_dq,
	output logic      [15:0] o_dq
);
	logic [15:0] mem [0:255];
	logic [15:0] rd_val;
	logic        id_mode;
	logic        armed;
	logic        locked;
	logic        tgl;
	realtime     busy_end;
	int          k;

	function automatic logic busy();
		return $realtime < busy_end;
	endfunction

	// small array aliases the upper address bits; enough for a few test words
	initial begin
		for (k = 0; k < 256; k++)
			mem[k] = 16'hFFFF;
		id_mode = 1'b0;
		armed = 1'b0;
		locked = 1'b0;
		tgl = 1'b0;
		busy_end = 0;
		o_dq = 16'h5A5A;
	end

	// a low reset pin stands in for power loss; the lockout is kept
	always @(negedge i_rst_n) begin
		id_mode = 1'b0;
		armed = 1'b0;
		busy_end = 0;
	end

	// writes are taken at the rising write strobe; busy ignores them
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_rst_n && !busy()) begin
			if (armed) begin
				armed = 1'b0;
				if (!(locked && i_addr <= 17'h01FFF)) begin
					mem[i_addr[7:0]] = i_dq;
					busy_end = $realtime + (i_slow ? SLOW_NS : FAST_NS);
				end
			end else begin
				case (i_dq[7:0])
					PROG_CODE: armed = 1'b1;
					ID_IN: id_mode = 1'b1;
					ID_OUT_A, ID_OUT_B: id_mode = 1'b0;
					LOCK_CODE: locked = 1'b1;
					8'h10, 8'h30: begin
						if (i_dq[7:0] == 8'h30 || i_addr[14:0] == 15'h5555) begin
							for (k = 0; k < 256; k++)
								mem[k] = 16'hFFFF;
							busy_end = $realtime + (i_slow ? SLOW_NS : FAST_NS);
						end
					end
					default: ;
				endcase
			end
		end
	end

	// data shows only after the access time; until then the bus is garbage
	always @(negedge i_oe_n or negedge i_ce_n) begin
		if (!i_oe_n && !i_ce_n) begin
			if (busy()) begin
				tgl = ~tgl;
				rd_val = {9'h000, tgl, 6'h00};
			end else if (id_mode && i_addr[16:1] == 16'h0000)
				rd_val = i_addr[0] ? PART_ID : MAKER_ID;
			else
				rd_val = mem[i_addr[7:0]];
			o_dq <= ~o_dq;
			o_dq <= #(ACC_NS) rd_val;
		end
	end

	// released bus never keeps the last word
	always @(posedge i_oe_n or posedge i_ce_n)
		o_dq <= ~o_dq;
endmodule
`default_nettype wire

// File: verification/flash_host_bench.sv
// self-checking bench for the flash host against a behavioural flash
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.svh"
module flash_host_bench import flash_host_pkg::*;;
	localparam logic [7:0]  PROG   = 8'hA0;
	localparam logic [7:0]  ID_IN  = 8'h90;
	localparam logic [7:0]  EXIT_A = 8'hF0;
	localparam logic [7:0]  EXIT_B = 8'hFF;
	localparam logic [7:0]  LOCK   = 8'h40;
	localparam logic [15:0] MAKER  = 16'h0011; // arbitrary value
	localparam logic [15:0] PART   = 16'h0022; // arbitrary value

	logic        i_core_clk;
	logic        i_nrst;
	logic        i_cmd_valid;
	op_t         i_cmd_op;
	logic [16:0] i_cmd_addr;
	logic [15:0] i_cmd_data;
	logic        o_cmd_ready;
	logic        o_cmd_done;
	logic [15:0] o_cmd_rdata;
	logic        o_cmd_timeout;
	logic        o_flash_ce_n;
	logic        o_flash_oe_n;
	logic        o_flash_we_n;
	logic        o_flash_rst_n;
	logic [16:0] o_flash_addr;
	logic [15:0] o_flash_dq_out;
	logic        o_flash_dq_oe;
	logic [15:0] dev_dq;
	logic [15:0] flash_dq;
	logic        slow;
	logic        poll_on;
	logic        tmo;
	logic        prev_oe;
	logic        prev_we;
	logic [16:0] poll_addr;
	logic [16:0] last_wa;
	logic [15:0] last_wd;
	logic [15:0] rdata;
	int          err_count;
	int          checks;
	int          hi_cnt;

	// the data wire: host when it drives, the device otherwise
	assign flash_dq = o_flash_dq_oe ? o_flash_dq_out : dev_dq;

	flash_host #(.PROG_TIMEOUT_CYC(400), .ERASE_TIMEOUT_CYC(2000)) i_flash_host (
		.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid),
		.i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
		.i_flash_dq_in(flash_dq), .o_cmd_ready(o_cmd_ready), .o_cmd_done(o_cmd_done),
		.o_cmd_rdata(o_cmd_rdata), .o_cmd_timeout(o_cmd_timeout),
		.o_flash_ce_n(o_flash_ce_n), .o_flash_oe_n(o_flash_oe_n),
		.o_flash_we_n(o_flash_we_n), .o_flash_rst_n(o_flash_rst_n),
		.o_flash_addr(o_flash_addr), .o_flash_dq_out(o_flash_dq_out),
		.o_flash_dq_oe(o_flash_dq_oe));

	flash_device_model #(.PROG_CODE(PROG), .ID_IN(ID_IN), .ID_OUT_A(EXIT_A),
		.ID_OUT_B(EXIT_B), .LOCK_CODE(LOCK), .MAKER_ID(MAKER), .PART_ID(PART))
	i_flash_device_model (
		.i_rst_n(o_flash_rst_n), .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n),
		.i_we_n(o_flash_we_n), .i_slow(slow), .i_addr(o_flash_addr),
		.i_dq(flash_dq), .o_dq(dev_dq));

	task automatic wrap_up();
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk_val(input string what, input logic [16:0] exp, input logic [16:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one command through the request port; one bound covers accept and done
	task automatic run(input op_t op, input logic [16:0] addr, input logic [15:0] data);
		int n;
		n = 0;
		i_cmd_op <= op;
		i_cmd_addr <= addr;
		i_cmd_data <= data;
		i_cmd_valid <= 1'b1;
		do
			@(posedge i_core_clk);
		while (o_cmd_ready !== 1'b1 && n++ < 5000);
		i_cmd_valid <= 1'b0;
		do
			@(posedge i_core_clk);
		while (o_cmd_done !== 1'b1 && n++ < 9000);
		if (n >= 9000) begin
			err_count++;
			wrap_up();
		end
		rdata = o_cmd_rdata;
		tmo = o_cmd_timeout;
	endtask

	task automatic rd(input logic [16:0] addr, input logic [15:0] exp);
		run(OP_READ, addr, 16'h0000);
		chk_val("read data", {1'b0, exp}, {1'b0, rdata});
	endtask

	task automatic poll_op(input op_t op, input logic [16:0] a, input logic [16:0] pa);
		poll_addr = pa;
		poll_on = 1'b1;
		run(op, a, 16'hFFFF);
		poll_on = 1'b0;
		chk_bit("poll timeout", 1'b0, tmo);
	endtask

	// the program preamble is sent as a plain write by the user
	task automatic prog(input logic [16:0] addr, input logic [15:0] data);
		run(OP_WRITE, 17'h05555, {8'h00, PROG});
		poll_addr = addr;
		poll_on = 1'b1;
		run(OP_PROGRAM, addr, data);
		poll_on = 1'b0;
	endtask

	task automatic t_reset();
		chk_bit("ce in reset", 1'b1, o_flash_ce_n);
		chk_bit("we in reset", 1'b1, o_flash_we_n);
		chk_bit("flash reset in reset", 1'b0, o_flash_rst_n);
		chk_bit("ready in reset", 1'b0, o_cmd_ready);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		chk_bit("flash reset after", 1'b1, o_flash_rst_n);
	endtask

	task automatic t_program();
		prog(17'h00123, 16'h1234);
		chk_bit("program timeout", 1'b0, tmo);
		rd(17'h00123, 16'h1234);
	endtask

	task automatic t_erase();
		poll_op(OP_CHIP_ERASE, 17'h1ABCD, 17'h05555);
		chk_val("erase address", 17'h05555, last_wa);
		chk_val("erase word", 17'h00010, {1'b0, last_wd});
		rd(17'h00123, 16'hFFFF);
		prog(17'h00124, 16'h0BAD);
		rd(17'h00124, 16'h0BAD);
		poll_op(OP_SECTOR_ERASE, 17'h00100, 17'h00100);
		chk_val("sector address", 17'h00100, last_wa);
		chk_val("sector word", 17'h00030, {1'b0, last_wd});
		rd(17'h00124, 16'hFFFF);
	endtask

	// both exit forms, then a reset that must drop id mode
	task automatic t_id();
		for (int f = 0; f < 2; f++) begin
			run(OP_WRITE, 17'h05555, {8'hAB, ID_IN});
			rd(17'h00000, MAKER);
			rd(17'h00001, PART);
			run(OP_WRITE, 17'h05555, {8'h00, (f == 1) ? EXIT_B : EXIT_A});
			rd(17'h00001, 16'hFFFF);
		end
		run(OP_WRITE, 17'h05555, {8'h00, ID_IN});
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		rd(17'h00000, 16'hFFFF);
	endtask

	task automatic t_lockout();
		run(OP_WRITE, 17'h05555, {8'h00, LOCK});
		prog(17'h01FFF, 16'h1111);
		rd(17'h01FFF, 16'hFFFF);
		prog(17'h02000, 16'h2222);
		rd(17'h02000, 16'h2222);
	endtask

	// a device slower than the limit must end in a timeout
	task automatic t_slow();
		slow = 1'b1;
		prog(17'h02001, 16'h3333);
		chk_bit("slow timeout", 1'b1, tmo);
	endtask

	// pin rules watched every cycle; values are the ones sampled at the edge
	always @(posedge i_core_clk) begin
		if (i_nrst) begin
			if (!o_flash_we_n && !o_flash_ce_n)
				chk_bit("oe during write", 1'b1, o_flash_oe_n);
			if (prev_oe && !o_flash_oe_n && poll_on) begin
				chk_bit("oe high gap", 1'b1, hi_cnt >= `MIN_STROBE_HIGH_PULSE_CYC);
				chk_val("poll address", poll_addr, o_flash_addr);
			end
			if (!prev_we && o_flash_we_n) begin
				last_wa = o_flash_addr;
				last_wd = o_flash_dq_out;
			end
		end
		hi_cnt = o_flash_oe_n ? hi_cnt + 1 : 0;
		prev_oe = o_flash_oe_n;
		prev_we = o_flash_we_n;
	end

	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end

	initial begin
		i_nrst = 1'b0;
		i_cmd_valid = 1'b0;
		i_cmd_op = OP_READ;
		i_cmd_addr = 17'h00000;
		i_cmd_data = 16'h0000;
		slow = 1'b0;
		poll_on = 1'b0;
		prev_oe = 1'b1;
		prev_we = 1'b1;
		hi_cnt = 0;
		err_count = 0;
		checks = 0;
		repeat (10) @(posedge i_core_clk);
		t_reset();
		t_program();
		t_erase();
		t_id();
		t_lockout();
		t_slow();
		wrap_up();
	end
endmodule
`default_nettype wire
